//--- rtl/arpc_defines.vh
`ifndef ARPC_DEFINES_VH
`define ARPC_DEFINES_VH
// ==========================================
// Command codes presented by the serial decoder
`define ARPC_CMD_W 3
`define ARPC_CMD_NONE 3'h0
`define ARPC_CMD_RESET 3'h1
`define ARPC_CMD_STANDBY 3'h2
`define ARPC_CMD_WAKEUP 3'h3
`define ARPC_CMD_SYNC 3'h4
`define ARPC_CMD_SELF_CALIBRATE_CMD 3'h5
// ==========================================
// Control register fields and defaults
`define ARPC_CTRL_CLK_LSB 0
`define ARPC_CTRL_CLK_MSB 1
`define ARPC_CTRL_RESET 8'h20
`define ARPC_RATE_RESET 8'hF0
`define ARPC_AUTO_CALIBRATION_ENABLE_RESET 1'b0
// ==========================================
// Timing: divide ratios, period and bit counts, and delays in master clock periods
`define ARPC_MOD_DIV 4
`define ARPC_DECIM 64
`define ARPC_PWDN_RESULT_READY_N_PERIODS 20
`define ARPC_PWDN_EXIT_CLKS 8192
`define ARPC_WAKE_EXTRA_CLKS 256
`define ARPC_CAL_CLKS 16'h0100
`define ARPC_SCLK_RESET_BITS 8
`endif

//--- rtl/arpc_counter.v
`timescale 1ns/10ps
// ==========================================
// Load-and-count-down timer
module arpc_counter (
  input wire sys_clk_in,
  input wire reset_in,
  input wire load_in,
  input wire [31:0] value_in,
  input wire step_in,
  output reg [31:0] count_out,
  output wire zero_out
);
  assign zero_out = (count_out == 32'h0);
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      count_out <= 32'h0;
    end else if (load_in) begin
      count_out <= value_in;
    end else if (step_in && !zero_out) begin
      count_out <= count_out - 32'h1;
    end
  end
endmodule

//--- rtl/arpc_control.v
`timescale 1ns/10ps
`include "arpc_defines.vh"
// How it works
// - At power-up registers load defaults, then self-calibration runs unprompted.
// - Reset pin, reset command and serial-clock pattern all cause one reset.
// - Reset command acts after all eight bits shift in, then self-releases.
// - Clock-pattern reset needs chip select low; acts on final edge, self-releases.
// - Resets restore defaults, but clock-out select only on reset pin.
// - Any reset ends continuous read-data mode.
// - Every reset is followed by self-calibration, ignoring the auto-cal bit.
// - Standby stops analog and most digital; wakeup resumes conversions.
// - After standby exit, result_ready_n stays high until valid data.
// - Clock output keeps running in standby when selected.
// - Pin low for 20 ready periods enters power-down, clock output stopped.
// - Pin high ends power-down; conversions wait 8192 master clocks.
// - While pin is low the serial interface is blocked.
// - Pin rising edge abandons conversion, restarts filter, starts new one.
// - Sync command halts; wakeup syncs on clock after its first serial clock.
// - result_ready_n goes high at pin fall and stays high through restart.
// - After any synchronisation result_ready_n stays high until valid result.
// - result_ready_n falls after settling time for the selected rate.
// - Single-shot from standby adds 256 master clocks before ready.
// - First flagged result after synchronisation is fully settled.
// - Modulator rate is master clock over 4; slow rates reject mains.
// - Output rate is decimation 64 then averager set by num_average_in.
module arpc_control (
  input wire sys_clk_in,
  input wire reset_in,
  input wire reset_pin_n_in,
  input wire sync_powerdown_n_in,
  input wire chip_select_n_in,
  input wire sclk_in,
  input wire sclk_first_in,
  input wire [`ARPC_CMD_W-1:0] command_in,
  input wire command_valid_in,
  input wire read_continuous_start_in,
  input wire reg_write_in,
  input wire [7:0] ctrl_write_in,
  input wire [7:0] rate_write_in,
  input wire auto_calibration_enable_write_in,
  input wire [15:0] num_average_in,
  input wire [3:0] settle_periods_in,
  input wire result_read_in,
  output reg result_ready_n_out,
  output reg [7:0] adc_control_reg_out,
  output reg [7:0] rate_select_reg_out,
  output reg auto_calibration_enable_out,
  output reg read_continuous_out,
  output reg analog_enable_out,
  output reg modulator_tick_out,
  output reg filter_restart_out,
  output reg calibrating_out,
  output reg gpio0_clock_out,
  output wire serial_enable_out,
  output reg in_standby_out,
  output reg in_powerdown_out
);
  // ==========================================
  // States
  localparam ST_CAL = 3'd0;
  localparam ST_RUN = 3'd1;
  localparam ST_STANDBY = 3'd2;
  localparam ST_HALT = 3'd3;
  localparam ST_SYNC_LOW = 3'd4;
  localparam ST_POWERDOWN = 3'd5;
  localparam ST_PD_EXIT = 3'd6;
  localparam ST_WAKE_DELAY = 3'd7;
  localparam [7:0] CTRL_DEFAULT = `ARPC_CTRL_RESET;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] mod_div;
  reg [7:0] decim_cnt;
  reg [15:0] avg_cnt;
  reg [3:0] settle_cnt;
  reg [4:0] low_periods;
  reg [23:0] low_clks;
  reg [2:0] clkout_div;
  reg sync_pin_q;
  reg sclk_q;
  reg [3:0] pattern_cnt;
  reg power_seen;
  reg timer_load;
  reg [31:0] timer_value;
  wire timer_zero;
  wire pin_reset;
  wire cmd_reset;
  wire pattern_reset;
  wire any_reset;
  wire converting;
  wire period_done;
  // ==========================================
  // Reset sources
  assign pin_reset = !reset_pin_n_in;
  // Decoder flags the command only after its eighth bit
  assign cmd_reset = command_valid_in && (command_in == `ARPC_CMD_RESET);
  assign pattern_reset = !chip_select_n_in && sclk_q && !sclk_in &&
    (pattern_cnt == `ARPC_SCLK_RESET_BITS - 1);
  assign any_reset = reset_in || pin_reset || cmd_reset || pattern_reset;
  assign serial_enable_out = sync_powerdown_n_in;
  assign converting = (state == ST_RUN);
  // ==========================================
  // Modulator tick, master clock over four
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      mod_div <= 2'h0;
      modulator_tick_out <= 1'b0;
    end else begin
      mod_div <= mod_div + 2'h1;
      modulator_tick_out <= (mod_div == 2'h3);
    end
  end
  // ==========================================
  // Simplified pattern detector: counts serial clock falling edges under chip select
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      sclk_q <= 1'b0;
      pattern_cnt <= 4'h0;
    end else begin
      sclk_q <= sclk_in;
      if (chip_select_n_in || pattern_reset) begin
        pattern_cnt <= 4'h0;
      end else if (sclk_q && !sclk_in) begin
        pattern_cnt <= pattern_cnt + 4'h1;
      end
    end
  end
  // ==========================================
  // Settling timer
  arpc_counter u_timer (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .load_in(timer_load),
    .value_in(timer_value),
    .step_in(1'b1),
    .count_out(),
    .zero_out(timer_zero)
  );
  // One output period: decimation 64 by modulator ticks, then averager
  assign period_done = converting && modulator_tick_out &&
    (decim_cnt == `ARPC_DECIM - 1) && (avg_cnt + 16'h1 >= num_average_in);
  // ==========================================
  // Next state
  always @* begin
    next_state = state;
    timer_load = 1'b0;
    timer_value = 32'h0;
    case (state)
      ST_CAL: begin
        if (timer_zero) begin
          next_state = ST_RUN;
        end
      end
      ST_RUN, ST_HALT, ST_STANDBY: begin
        if (command_valid_in && command_in == `ARPC_CMD_STANDBY) begin
          next_state = ST_STANDBY;
        end else if (command_valid_in && command_in == `ARPC_CMD_SYNC) begin
          next_state = ST_HALT;
        end else if (command_valid_in && command_in == `ARPC_CMD_SELF_CALIBRATE_CMD) begin
          next_state = ST_CAL;
          timer_load = 1'b1;
          timer_value = {16'h0, `ARPC_CAL_CLKS};
        end else if (state == ST_STANDBY && sclk_first_in) begin
          next_state = ST_WAKE_DELAY;
          timer_load = 1'b1;
          timer_value = `ARPC_WAKE_EXTRA_CLKS;
        end else if (state == ST_HALT && sclk_first_in) begin
          next_state = ST_RUN;
        end
      end
      ST_WAKE_DELAY: begin
        if (timer_zero) begin
          next_state = ST_RUN;
        end
      end
      ST_SYNC_LOW: begin
        if (sync_powerdown_n_in) begin
          next_state = ST_RUN;
        end else if (low_periods == `ARPC_PWDN_RESULT_READY_N_PERIODS) begin
          next_state = ST_POWERDOWN;
        end
      end
      ST_POWERDOWN: begin
        if (sync_powerdown_n_in) begin
          next_state = ST_PD_EXIT;
          timer_load = 1'b1;
          timer_value = `ARPC_PWDN_EXIT_CLKS;
        end
      end
      ST_PD_EXIT: begin
        if (timer_zero) begin
          next_state = ST_RUN;
        end
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
    // Pin fall overrides command activity, except while powered down or calibrating
    if (!sync_powerdown_n_in && state != ST_SYNC_LOW && state != ST_POWERDOWN &&
        state != ST_CAL) begin
      next_state = ST_SYNC_LOW;
      timer_load = 1'b0;
    end
    if (any_reset || !power_seen) begin
      next_state = ST_CAL;
      timer_load = 1'b1;
      timer_value = {16'h0, `ARPC_CAL_CLKS};
    end
  end
  // ==========================================
  // State and registers
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      state <= ST_CAL;
      power_seen <= 1'b0;
      sync_pin_q <= 1'b1;
      adc_control_reg_out <= `ARPC_CTRL_RESET;
      rate_select_reg_out <= `ARPC_RATE_RESET;
      auto_calibration_enable_out <= `ARPC_AUTO_CALIBRATION_ENABLE_RESET;
      read_continuous_out <= 1'b0;
    end else begin
      state <= next_state;
      power_seen <= 1'b1;
      sync_pin_q <= sync_powerdown_n_in;
      if (any_reset) begin
        adc_control_reg_out[7:2] <= CTRL_DEFAULT[7:2];
        if (pin_reset) begin
          adc_control_reg_out[1:0] <= CTRL_DEFAULT[1:0];
        end
        rate_select_reg_out <= `ARPC_RATE_RESET;
        auto_calibration_enable_out <= `ARPC_AUTO_CALIBRATION_ENABLE_RESET;
        read_continuous_out <= 1'b0;
      end else begin
        if (reg_write_in && sync_powerdown_n_in) begin
          adc_control_reg_out <= ctrl_write_in;
          rate_select_reg_out <= rate_write_in;
          auto_calibration_enable_out <= auto_calibration_enable_write_in;
        end
        if (read_continuous_start_in && sync_powerdown_n_in) begin
          read_continuous_out <= 1'b1;
        end
      end
    end
  end
  // ==========================================
  // Conversion period counters and ready output
  always @(posedge sys_clk_in) begin
    if (reset_in || !converting) begin
      decim_cnt <= 8'h0;
      avg_cnt <= 16'h0;
      settle_cnt <= 4'h0;
      result_ready_n_out <= 1'b1;
    end else begin
      if (modulator_tick_out) begin
        decim_cnt <= (decim_cnt == `ARPC_DECIM - 1) ? 8'h0 : decim_cnt + 8'h1;
        if (decim_cnt == `ARPC_DECIM - 1) begin
          avg_cnt <= period_done ? 16'h0 : avg_cnt + 16'h1;
        end
      end
      if (result_read_in) begin
        result_ready_n_out <= 1'b1;
      end
      // Set below wins over a read in the same cycle, so no result is lost
      if (period_done) begin
        // Hold off until filter history is full, so first flag is settled
        if (settle_cnt + 4'h1 >= settle_periods_in) begin
          result_ready_n_out <= 1'b0;
        end else begin
          settle_cnt <= settle_cnt + 4'h1;
        end
      end
    end
  end
  // ==========================================
  // Power-down entry: ready periods counted while the pin is low
  // Filter counters are held here, so count master clocks instead
  // One nominal period is 256 master clocks per average
  always @(posedge sys_clk_in) begin
    if (reset_in || state != ST_SYNC_LOW) begin
      low_periods <= 5'h0;
      low_clks <= 24'h0;
    end else if (low_clks + 24'h1 >= {num_average_in, 8'h00}) begin
      low_clks <= 24'h0;
      if (low_periods != `ARPC_PWDN_RESULT_READY_N_PERIODS) begin
        low_periods <= low_periods + 5'h1;
      end
    end else begin
      low_clks <= low_clks + 24'h1;
    end
  end
  // ==========================================
  // Status outputs: analog enable, filter restart and state flags
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      analog_enable_out <= 1'b0;
      filter_restart_out <= 1'b0;
      calibrating_out <= 1'b0;
      in_standby_out <= 1'b0;
      in_powerdown_out <= 1'b0;
    end else begin
      analog_enable_out <= (next_state == ST_RUN) || (next_state == ST_CAL) ||
        (next_state == ST_WAKE_DELAY);
      // Pin rising edge; the held value resets high so reset gives no false edge
      filter_restart_out <= sync_powerdown_n_in && !sync_pin_q;
      calibrating_out <= (next_state == ST_CAL);
      in_standby_out <= (next_state == ST_STANDBY);
      in_powerdown_out <= (next_state == ST_POWERDOWN);
    end
  end
  // ==========================================
  // Clock output divider
  // Runs on in standby on purpose; only power-down and select zero stop it
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      clkout_div <= 3'h0;
      gpio0_clock_out <= 1'b0;
    end else begin
      clkout_div <= clkout_div + 3'h1;
      if (state == ST_POWERDOWN) begin
        gpio0_clock_out <= 1'b0;
      end else begin
        // Select: 0 off, else master clock over 2, 4 or 8
        case (adc_control_reg_out[1:0])
          2'h1: gpio0_clock_out <= clkout_div[0];
          2'h2: gpio0_clock_out <= clkout_div[1];
          2'h3: gpio0_clock_out <= clkout_div[2];
          default: gpio0_clock_out <= 1'b0;
        endcase
      end
    end
  end
endmodule

//--- test/arpc_monitor.sv
`timescale 1ns/10ps
`include "arpc_defines.vh"
// ==========================================
// Port checker
module arpc_monitor (
  input wire sys_clk_in,
  input wire reset_in,
  input wire sync_powerdown_n_in,
  input wire [`ARPC_CMD_W-1:0] command_in,
  input wire command_valid_in,
  input wire result_read_in,
  input wire result_ready_n_out,
  input wire read_continuous_out,
  input wire analog_enable_out,
  input wire calibrating_out,
  input wire gpio0_clock_out,
  input wire serial_enable_out,
  input wire in_standby_out,
  input wire in_powerdown_out,
  input wire modulator_tick_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // ==========================================
  // Assertions
  chk_cal_after_reset: assert property ($fell(reset_in) |-> ##[0:4] calibrating_out)
    else $error("no calibration after reset");
  chk_serial_block: assert property (serial_enable_out == sync_powerdown_n_in)
    else $error("serial enable differs from sync pin");
  chk_sync_low_ready: assert property (!sync_powerdown_n_in [*4] |-> result_ready_n_out)
    else $error("ready low while sync pin low");
  chk_sync_rise_hold: assert property ($rose(sync_powerdown_n_in)
    |-> result_ready_n_out [*8])
    else $error("ready low right after sync rise");
  chk_pd_entry_cause: assert property ($rose(in_powerdown_out)
    |-> !$past(sync_powerdown_n_in, 3))
    else $error("power-down without sync pin low");
  chk_tick_gap: assert property (modulator_tick_out |=> !modulator_tick_out [*3])
    else $error("modulator tick too soon");
  chk_tick_period: assert property (modulator_tick_out |-> ##4 modulator_tick_out)
    else $error("modulator tick missing");
  chk_pd_clock_stop: assert property (in_powerdown_out [*3] |-> $stable(gpio0_clock_out))
    else $error("clock output runs in power-down");
  chk_standby_analog: assert property (in_standby_out [*3] |-> !analog_enable_out)
    else $error("analog on in standby");
  chk_reset_cmd_mode: assert property (command_valid_in && command_in == `ARPC_CMD_RESET
    |-> ##[1:4] !read_continuous_out)
    else $error("continuous mode survives reset");
  chk_read_clears: assert property (result_read_in && !result_ready_n_out
    |-> ##[1:3] result_ready_n_out)
    else $error("read does not clear ready");
  cover property ($fell(result_ready_n_out));
  cover property (in_powerdown_out);
  cover property (in_standby_out && $changed(gpio0_clock_out));
endmodule

//--- test/arpc_host_model.sv
`timescale 1ns/10ps
// ==========================================
// Host controller on the serial side
module arpc_host_model (
  input wire sys_clk_in,
  input wire sync_powerdown_n_in,
  output reg chip_select_n_out,
  output reg sclk_out,
  output reg sclk_first_out,
  output reg [2:0] command_out,
  output reg command_valid_out
);
  integer i;
  initial begin
    chip_select_n_out = 1'b1;
    sclk_out = 1'b0;
    sclk_first_out = 1'b0;
    command_out = 3'h7;
    command_valid_out = 1'b0;
  end
  // Pattern has eight clocks and no decoded byte, so it can only mean reset
  task send(input [2:0] cmd, input pattern);
    begin
      while (sync_powerdown_n_in !== 1'b1) @(negedge sys_clk_in);
      @(negedge sys_clk_in);
      chip_select_n_out = 1'b0;
      for (i = 0; i < (pattern ? 8 : 1); i = i + 1) begin
        sclk_out = 1'b1;
        sclk_first_out = !pattern;
        @(negedge sys_clk_in);
        sclk_out = 1'b0;
        sclk_first_out = 1'b0;
        @(negedge sys_clk_in);
      end
      command_out = cmd;
      command_valid_out = !pattern;
      @(negedge sys_clk_in);
      command_valid_out = 1'b0;
      command_out = ~cmd;
      chip_select_n_out = 1'b1;
    end
  endtask
endmodule

//--- test/adc_reset_sync_power_control_tb.sv
`timescale 1ns/10ps
`include "arpc_defines.vh"
module adc_reset_sync_power_control_tb;
  reg sys_clk_in = 1'b0;
  reg reset_in = 1'b1;
  reg reset_pin_n_in = 1'b1;
  reg sync_powerdown_n_in = 1'b1;
  reg read_continuous_start_in = 1'b0;
  reg reg_write_in = 1'b0;
  reg [7:0] ctrl_write_in = 8'h00;
  reg [7:0] rate_write_in = 8'h00;
  reg auto_calibration_enable_write_in = 1'b0;
  reg result_read_in = 1'b0;
  reg [15:0] num_average_in = 16'h0001;
  reg [3:0] settle_periods_in = 4'h1;
  reg g0;
  wire chip_select_n_in, sclk_in, sclk_first_in, command_valid_in, result_ready_n_out;
  wire read_continuous_out, analog_enable_out, modulator_tick_out, filter_restart_out;
  wire calibrating_out, gpio0_clock_out, serial_enable_out, in_standby_out, in_powerdown_out;
  wire auto_calibration_enable_out;
  wire [2:0] command_in;
  wire [7:0] adc_control_reg_out, rate_select_reg_out;
  integer bad_count = 0;
  integer checks = 0;
  integer n;
  localparam integer PER = `ARPC_DECIM * `ARPC_MOD_DIV;
  always #5 sys_clk_in = ~sys_clk_in;
  // Averager and settle count start at one to keep every wait short
  arpc_control dut (.sys_clk_in, .reset_in, .reset_pin_n_in, .sync_powerdown_n_in,
    .chip_select_n_in, .sclk_in, .sclk_first_in, .command_in, .command_valid_in,
    .read_continuous_start_in, .reg_write_in, .ctrl_write_in, .rate_write_in, .auto_calibration_enable_write_in,
    .num_average_in, .settle_periods_in, .result_read_in, .result_ready_n_out,
    .adc_control_reg_out, .rate_select_reg_out, .auto_calibration_enable_out,
    .read_continuous_out, .analog_enable_out, .modulator_tick_out, .filter_restart_out,
    .calibrating_out, .gpio0_clock_out, .serial_enable_out, .in_standby_out, .in_powerdown_out);
  arpc_host_model host (.sys_clk_in(sys_clk_in), .sync_powerdown_n_in(sync_powerdown_n_in),
    .chip_select_n_out(chip_select_n_in), .sclk_out(sclk_in), .sclk_first_out(sclk_first_in),
    .command_out(command_in), .command_valid_out(command_valid_in));
  // ==========================================
  // Helpers
  task chk(input ok, input [8*24-1:0] msg);
    begin
      checks = checks + 1;
      if (ok !== 1'b1) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: %0s", $time, msg);
      end
    end
  endtask
  task cyc(input integer k);
    repeat (k) @(negedge sys_clk_in);
  endtask
  task wait_ready(output integer c);
    begin
      c = 0;
      while (result_ready_n_out !== 1'b0 && c < 20000) begin
        cyc(1);
        c = c + 1;
      end
      chk(c < 20000, "ready never fell");
    end
  endtask
  task write_regs(input [7:0] c, input [7:0] r);
    begin
      ctrl_write_in = c;
      rate_write_in = r;
      auto_calibration_enable_write_in = 1'b1;
      reg_write_in = 1'b1;
      cyc(1);
      reg_write_in = 1'b0;
      cyc(3);
    end
  endtask
  // ==========================================
  // Scenarios
  task t_reset_paths;
    begin
      write_regs(8'h03, 8'h13);
      read_continuous_start_in = 1'b1;
      cyc(1);
      read_continuous_start_in = 1'b0;
      cyc(3);
      chk(rate_select_reg_out === 8'h13 && read_continuous_out === 1'b1, "write lost");
      host.send(`ARPC_CMD_RESET, 1'b0);
      cyc(4);
      chk(rate_select_reg_out === `ARPC_RATE_RESET && auto_calibration_enable_out === 1'b0,
        "command reset");
      chk(adc_control_reg_out === ((`ARPC_CTRL_RESET & 8'hFC) | 8'h03)
        && read_continuous_out === 1'b0, "clock bits or mode");
      wait_ready(n);
      write_regs(8'h03, 8'h13);
      host.send(3'h0, 1'b1);
      cyc(4);
      chk(rate_select_reg_out === `ARPC_RATE_RESET, "pattern reset");
      reset_pin_n_in = 1'b0;
      cyc(4);
      reset_pin_n_in = 1'b1;
      cyc(4);
      chk(adc_control_reg_out === `ARPC_CTRL_RESET, "pin reset");
    end
  endtask
  task t_sync_pin;
    begin
      wait_ready(n);
      sync_powerdown_n_in = 1'b0;
      cyc(3);
      chk(result_ready_n_out === 1'b1, "ready low in sync");
      write_regs(8'h00, 8'h53);
      chk(rate_select_reg_out === `ARPC_RATE_RESET, "write taken in sync");
      sync_powerdown_n_in = 1'b1;
      n = 0;
      repeat (4) begin
        cyc(1);
        if (filter_restart_out === 1'b1) n = 1;
      end
      chk(n == 1, "no filter restart");
      wait_ready(n);
      chk(n >= PER - 8, "early after sync");
      result_read_in = 1'b1;
      cyc(1);
      result_read_in = 1'b0;
      cyc(2);
      chk(result_ready_n_out === 1'b1, "read kept ready");
      wait_ready(n);
      chk(n >= PER - 16 && n <= PER + 4, "result period");
      num_average_in = 16'h0002;
      result_read_in = 1'b1;
      cyc(1);
      result_read_in = 1'b0;
      wait_ready(n);
      chk(n >= 2 * PER - 16 && n <= 2 * PER + 4, "averaged period");
      num_average_in = 16'h0001;
    end
  endtask
  task t_sync_cmd;
    begin
      host.send(`ARPC_CMD_SYNC, 1'b0);
      cyc(2 * PER);
      chk(result_ready_n_out === 1'b1, "ready while halted");
      settle_periods_in = 4'h2;
      host.send(`ARPC_CMD_WAKEUP, 1'b0);
      wait_ready(n);
      chk(n >= PER - 8, "early after wakeup");
      chk(n >= 2 * PER - 8 && n <= 2 * PER + 4, "settle periods");
      settle_periods_in = 4'h1;
    end
  endtask
  task t_standby;
    begin
      write_regs(8'h21, `ARPC_RATE_RESET);
      host.send(`ARPC_CMD_STANDBY, 1'b0);
      cyc(4);
      chk(in_standby_out === 1'b1 && analog_enable_out === 1'b0, "no standby");
      g0 = gpio0_clock_out;
      n = 0;
      repeat (64) begin
        cyc(1);
        if (gpio0_clock_out !== g0) n = 1;
      end
      chk(n == 1, "clock out stopped");
      host.send(`ARPC_CMD_WAKEUP, 1'b0);
      wait_ready(n);
      chk(n >= `ARPC_WAKE_EXTRA_CLKS + PER - 8 && in_standby_out === 1'b0,
        "single shot delay");
    end
  endtask
  task t_powerdown;
    begin
      sync_powerdown_n_in = 1'b0;
      cyc((`ARPC_PWDN_RESULT_READY_N_PERIODS - 1) * PER);
      chk(in_powerdown_out === 1'b0, "power-down too early");
      cyc(PER + 300);
      chk(in_powerdown_out === 1'b1, "no power-down");
      sync_powerdown_n_in = 1'b1;
      wait_ready(n);
      chk(n >= `ARPC_PWDN_EXIT_CLKS, "early after power-down");
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d bad_count %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    cyc(8);
    reset_in = 1'b0;
    wait_ready(n);
    chk(n >= `ARPC_CAL_CLKS + PER - 4, "early ready at start");
    t_reset_paths;
    t_sync_pin;
    t_sync_cmd;
    t_standby;
    t_powerdown;
    stop_test;
  end
  // Whole run is near 18k cycles; this allows about twice that
  initial begin
    #400000;
    bad_count = bad_count + 1;
    stop_test;
  end
endmodule
bind arpc_control arpc_monitor mon (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
  .sync_powerdown_n_in(sync_powerdown_n_in), .command_in(command_in),
  .command_valid_in(command_valid_in), .result_read_in(result_read_in),
  .result_ready_n_out(result_ready_n_out), .read_continuous_out(read_continuous_out),
  .analog_enable_out(analog_enable_out), .calibrating_out(calibrating_out),
  .gpio0_clock_out(gpio0_clock_out), .serial_enable_out(serial_enable_out),
  .in_standby_out(in_standby_out), .in_powerdown_out(in_powerdown_out),
  .modulator_tick_out(modulator_tick_out));
